// [core/dfs_avmm_slave.sv]
`timescale 1ns/1ps
// small avalon-mm slave: one control word, one status word, answers after one wait cycle
module dfs_avmm_slave (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // avalon-mm
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // block side
  input wire logic [31:0] status_i,
  output logic double_density_o
);
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STAT = 4'h4;
  logic served;
  logic next_served;
  logic [31:0] next_rdata;
  logic next_dd;

  always_comb begin
    next_served = (avs_read | avs_write) & ~served;
    next_rdata = avs_readdata;
    next_dd = double_density_o;
    if (avs_read & ~served) begin
      if (avs_address == OFS_CTRL) begin
        next_rdata = {31'h0, double_density_o};
      end else if (avs_address == OFS_STAT) begin
        next_rdata = status_i;
      end else begin
        next_rdata = 32'h0;
      end
    end
    if (avs_write & ~served & (avs_address == OFS_CTRL)) begin
      next_dd = avs_writedata[0];
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      served <= 1'b0;
      avs_readdata <= 32'h0;
      double_density_o <= 1'b0;
      avs_waitrequest <= 1'b1;
    end else begin
      served <= next_served;
      avs_readdata <= next_rdata;
      double_density_o <= next_dd;
      // registered, so idle shows high; a request still completes one cycle after it arrives
      avs_waitrequest <= ~next_served;
    end
  end
endmodule : dfs_avmm_slave

// [core/dfs_phase_sync.sv]
`timescale 1ns/1ps
// two-flop synchroniser and rising-edge detector for the phase-one pulse
module dfs_phase_sync (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // pulse in and out
  input wire logic pulse_i,
  output logic rise_o
);
  logic s1;
  logic s2;
  logic s3;
  logic next_rise;

  always_comb begin
    next_rise = s2 & ~s3;
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      rise_o <= 1'b0;
    end else begin
      s1 <= pulse_i;
      s2 <= s1;
      s3 <= s2;
      rise_o <= next_rise;
    end
  end
endmodule : dfs_phase_sync

// [core/dfs_pkg.sv]
package dfs_pkg;

  // command word layout: bit 00 is the most significant bit of a 32-bit word
  localparam int CMD_W = 32;
  localparam int RF_AW = 4;
  localparam int RF_DW = 16;
  localparam int INFO_W = 10;
  localparam int UNIT_W = 6;

  // tag-bit positions, counted from the msb as the command format numbers them
  localparam int BIT_USEL_EN = 8;
  localparam int BIT_USEL_DIS = 9;
  localparam int BIT_LD_DIFF = 10;
  localparam int BIT_LD_CYL = 11;
  localparam int BIT_LD_SEC = 12;
  localparam int BIT_LD_HEAD = 13;
  localparam int BIT_CSEL = 14;
  localparam int BIT_DIS_RSV = 24;
  localparam int BIT_FROM_RF = 25;
  localparam int OPND_LO = 15;
  localparam int OPND_HI = 23;
  localparam int RFA_LO = 28;
  localparam int RF_INFO_LO = 7;
  localparam int RF_INFO_LO_DD = 6;

  localparam logic [7:0] FUNC_CODE_DISK = 8'hc0;
  localparam logic [INFO_W-1:0] INFO_RST = 10'h000;
  localparam logic [UNIT_W-1:0] UNIT_RST = 6'h00;

  // address tags toward the drive
  typedef struct packed {
    logic diff;
    logic cyl;
    logic sec;
    logic head;
  } dfs_tags_t;

  typedef struct packed {
    dfs_tags_t tags;
    logic control_select_line;
    logic control_info_gate;
    logic addr_gate;
    logic [INFO_W-1:0] info;
    logic unit_select_out;
    logic unit_receiver_enable;
    logic [UNIT_W-1:0] unit_sel;
    logic release_strobe;
    logic fault_clear_strobe;
    logic disable_reserve_signal;
  } dfs_drive_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_STEP1,
    ST_STEP2,
    ST_PULSE,
    ST_DROP,
    ST_FINAL
  } dfs_state_t;

  // msb-numbered bit fetch
  function automatic logic cbit(input logic [CMD_W-1:0] w, input int n);
    return w[CMD_W-1-n];
  endfunction : cbit

endpackage : dfs_pkg

// [core/dfs_sequencer.sv]
// Implementation choices: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
// Notes on behaviour
// - on read strobe, latch command word and raise function and counter-load decodes
// - command bits 08..14 select how the information is used at the drive
// - information comes from operand 15..23 or register file 07..15 (06..15 double density)
// - tag bits: 8 usel on, 9 usel off, 10..13 address loads, 14 control select
// - execute strobe loads register-file address counter from bits 28..31
// - execute strobe sets active flag and starts timing chain
// - source flag captures bit 25: set picks register file, clear picks operand
// - disable-reserve flag captures bit 24 on execute strobe
// - first phase-one step loads address/control register and clocks enable flags; code only loads the information here
// - next step with bit 14: raise control-select line and gate control info
// - next step without bit 14: raise chosen address tag and drive address
// - bit 8 loads unit-select register with operand bits 0,1,2,4,5 and inverted 3
// - following step drops tags and sets drive-pulse flag
// - drive pulse with disable-reserve flag sends disable-reserve signal
// - bit 8: release/fault-clear strobes in pulse, gated by unit-select bits 4/5
// - same step: unit-select enable sets on bit 8, clears on bit 9
// - next step clears function enable and removes address from drive; code only drops the address gate here
// - final step clears active and drive-pulse flags
// - final step raises command done
// - control-select line stays until a disable-control-select command
module dfs_sequencer (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // command fetch side
  input wire logic command_read_strobe_i,
  input wire logic [dfs_pkg::CMD_W-1:0] cmd_word_i,
  input wire logic execute_enable_strobe_i,
  input wire logic disable_control_select_i,
  output logic function_command_decode_o,
  output logic disk_function_decode_o,
  output logic regfile_counter_load_decode_o,
  output logic [dfs_pkg::RF_AW-1:0] rf_addr_o,
  input wire logic [dfs_pkg::RF_DW-1:0] rf_data_i,
  output logic command_done_o,
  output logic busy_o,
  // timing pulse from the clock generator, asynchronous
  input wire logic internal_phase_one_i,
  // drive interface
  output dfs_pkg::dfs_drive_t drive_o,
  // register bus
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  import dfs_pkg::*;

  logic ph1;
  logic dd;
  dfs_state_t state;
  dfs_state_t next_state;
  logic [CMD_W-1:0] cmd;
  logic [CMD_W-1:0] next_cmd;
  logic [RF_AW-1:0] rfa;
  logic [RF_AW-1:0] next_rfa;
  logic active;
  logic next_active;
  logic from_rf;
  logic next_from_rf;
  logic dis_rsv;
  logic next_dis_rsv;
  logic pulse;
  logic next_pulse;
  logic done;
  logic next_done;
  logic fn_dec;
  logic next_fn_dec;
  logic disk_dec;
  logic next_disk_dec;
  dfs_drive_t drv;
  dfs_drive_t next_drv;
  logic [INFO_W-1:0] src_info;

  dfs_phase_sync u_sync (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .pulse_i(internal_phase_one_i),
    .rise_o(ph1)
  );

  dfs_avmm_slave u_regs (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .status_i({22'h0, drv.unit_sel, from_rf, dis_rsv, pulse, active}),
    .double_density_o(dd)
  );

  // information source: msb-numbered bits mean rf bit 15 is lsb
  always_comb begin
    if (from_rf) begin
      if (dd) begin
        src_info = rf_data_i[INFO_W-1:0];
      end else begin
        src_info = {1'b0, rf_data_i[INFO_W-2:0]};
      end
    end else begin
      src_info = {1'b0, cmd[CMD_W-1-OPND_HI +: INFO_W-1]};
    end
  end

  always_comb begin
    next_state = state;
    next_cmd = cmd;
    next_rfa = rfa;
    next_active = active;
    next_from_rf = from_rf;
    next_dis_rsv = dis_rsv;
    next_pulse = pulse;
    next_done = 1'b0;
    next_fn_dec = fn_dec;
    next_disk_dec = disk_dec;
    next_drv = drv;
    if (command_read_strobe_i) begin
      next_cmd = cmd_word_i;
      next_fn_dec = 1'b1;
      next_disk_dec = (cmd_word_i[CMD_W-1 -: 8] == FUNC_CODE_DISK);
    end
    if (execute_enable_strobe_i && disk_dec && state == ST_IDLE) begin
      next_rfa = cmd[RF_AW-1:0];
      next_active = 1'b1;
      next_from_rf = cbit(cmd, BIT_FROM_RF);
      next_dis_rsv = cbit(cmd, BIT_DIS_RSV);
      next_fn_dec = 1'b0;
      next_disk_dec = 1'b0;
      next_state = ST_STEP1;
    end
    if (disable_control_select_i) begin
      next_drv.control_select_line = 1'b0;
      next_drv.control_info_gate = 1'b0;
    end
    if (ph1) begin
      case (state)
        ST_STEP1: begin
          next_drv.info = src_info;
          next_state = ST_STEP2;
        end
        ST_STEP2: begin
          if (cbit(cmd, BIT_CSEL)) begin
            next_drv.control_select_line = 1'b1;
            next_drv.control_info_gate = 1'b1;
          end else begin
            next_drv.tags.diff = cbit(cmd, BIT_LD_DIFF);
            next_drv.tags.cyl = cbit(cmd, BIT_LD_CYL);
            next_drv.tags.sec = cbit(cmd, BIT_LD_SEC);
            next_drv.tags.head = cbit(cmd, BIT_LD_HEAD);
            next_drv.addr_gate = 1'b1;
          end
          if (cbit(cmd, BIT_USEL_EN)) begin
            // operand bits 0..5 sit at word bits 16..11; operand bit 3 goes in inverted
            next_drv.unit_sel = cmd[CMD_W-1-OPND_LO -: UNIT_W] ^ 6'h04;
          end
          next_state = ST_PULSE;
        end
        ST_PULSE: begin
          next_drv.tags = '0;
          next_pulse = 1'b1;
          next_drv.disable_reserve_signal = dis_rsv;
          if (cbit(cmd, BIT_USEL_EN)) begin
            next_drv.release_strobe = drv.unit_sel[1];
            next_drv.fault_clear_strobe = drv.unit_sel[0];
            next_drv.unit_select_out = 1'b1;
            next_drv.unit_receiver_enable = 1'b1;
          end else if (cbit(cmd, BIT_USEL_DIS)) begin
            next_drv.unit_select_out = 1'b0;
            next_drv.unit_receiver_enable = 1'b0;
          end
          next_state = ST_DROP;
        end
        ST_DROP: begin
          next_drv.addr_gate = 1'b0;
          next_state = ST_FINAL;
        end
        ST_FINAL: begin
          next_active = 1'b0;
          next_pulse = 1'b0;
          next_drv.release_strobe = 1'b0;
          next_drv.fault_clear_strobe = 1'b0;
          next_drv.disable_reserve_signal = 1'b0;
          next_done = 1'b1;
          next_state = ST_IDLE;
        end
        default: begin
          next_state = state;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= ST_IDLE;
      cmd <= '0;
      rfa <= '0;
      active <= 1'b0;
      from_rf <= 1'b0;
      dis_rsv <= 1'b0;
      pulse <= 1'b0;
      done <= 1'b0;
      fn_dec <= 1'b0;
      disk_dec <= 1'b0;
      drv <= '0;
    end else begin
      state <= next_state;
      cmd <= next_cmd;
      rfa <= next_rfa;
      active <= next_active;
      from_rf <= next_from_rf;
      dis_rsv <= next_dis_rsv;
      pulse <= next_pulse;
      done <= next_done;
      fn_dec <= next_fn_dec;
      disk_dec <= next_disk_dec;
      drv <= next_drv;
    end
  end

  assign drive_o = drv;
  assign rf_addr_o = rfa;
  assign command_done_o = done;
  assign busy_o = active;
  assign function_command_decode_o = fn_dec;
  assign disk_function_decode_o = disk_dec;
  assign regfile_counter_load_decode_o = disk_dec;

  // tracks phase-one pulses seen since start, for checking the chain
  logic [2:0] ph_cnt;
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ph_cnt <= 3'h0;
    end else if (state == ST_IDLE) begin
      ph_cnt <= 3'h0;
    end else if (ph1) begin
      ph_cnt <= ph_cnt + 3'h1;
    end
  end

  property p_start;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      (execute_enable_strobe_i && disk_dec && state == ST_IDLE) |=> (active && state == ST_STEP1);
  endproperty
  a_start: assert property (p_start) else $error("chain did not start");

  property p_rfa;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      (execute_enable_strobe_i && disk_dec && state == ST_IDLE) |=> (rfa == $past(cmd[RF_AW-1:0]));
  endproperty
  a_rfa: assert property (p_rfa) else $error("rf counter not loaded");

  property p_rsv;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      (execute_enable_strobe_i && disk_dec && state == ST_IDLE) |=> (dis_rsv == $past(cmd[CMD_W-1-BIT_DIS_RSV]));
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserve flag wrong");

  property p_csel;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      (ph1 && state == ST_STEP2 && cbit(cmd, BIT_CSEL)) |=> drv.control_select_line && drv.control_info_gate;
  endproperty
  a_csel: assert property (p_csel) else $error("control select not raised");

  property p_tags_drop;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      (ph1 && state == ST_PULSE) |=> (drv.tags == '0) && pulse;
  endproperty
  a_tags_drop: assert property (p_tags_drop) else $error("tags not dropped");

  property p_disable_reserve_signal;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      drv.disable_reserve_signal |-> (pulse && dis_rsv);
  endproperty
  a_disable_reserve_signal: assert property (p_disable_reserve_signal) else $error("disable reserve outside pulse");

  property p_final;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      (ph1 && state == ST_FINAL) |=> done && !active && !pulse ##1 !done;
  endproperty
  a_final: assert property (p_final) else $error("final step wrong");

  property p_steps;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      (state != ST_IDLE) |-> (ph_cnt == 3'(state) - 3'h1);
  endproperty
  a_steps: assert property (p_steps) else $error("chain skipped a step");

  property p_csel_hold;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      (drv.control_select_line && !disable_control_select_i) |=> drv.control_select_line;
  endproperty
  a_csel_hold: assert property (p_csel_hold) else $error("control select dropped");

  property p_decode;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      (command_read_strobe_i && !execute_enable_strobe_i) |=> function_command_decode_o &&
        (disk_function_decode_o == ($past(cmd_word_i[CMD_W-1 -: 8]) == FUNC_CODE_DISK));
  endproperty
  a_decode: assert property (p_decode) else $error("command decodes wrong");

  property p_src;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      (ph1 && state == ST_STEP1) |=> (drv.info == $past(src_info));
  endproperty
  a_src: assert property (p_src) else $error("information not loaded");

  property p_tags;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      (ph1 && state == ST_STEP2 && !cbit(cmd, BIT_CSEL)) |=>
        drv.addr_gate && (drv.tags == $past(cmd[CMD_W-1-BIT_LD_DIFF -: 4]));
  endproperty
  a_tags: assert property (p_tags) else $error("address tags wrong");

  property p_usel;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      (ph1 && state == ST_STEP2 && cbit(cmd, BIT_USEL_EN)) |=>
        (drv.unit_sel[5:3] == $past(cmd[CMD_W-1-OPND_LO -: 3])) &&
        (drv.unit_sel[2] == !$past(cmd[CMD_W-4-OPND_LO])) && (drv.unit_sel[1:0] == $past(cmd[CMD_W-5-OPND_LO -: 2]));
  endproperty
  a_usel: assert property (p_usel) else $error("unit select register wrong");

  property p_rel;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      drv.release_strobe |-> (pulse && drv.unit_sel[1]);
  endproperty
  a_rel: assert property (p_rel) else $error("release strobe outside pulse");

  property p_fclr;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      drv.fault_clear_strobe |-> (pulse && drv.unit_sel[0]);
  endproperty
  a_fclr: assert property (p_fclr) else $error("fault clear strobe outside pulse");

  property p_usel_en;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      (ph1 && state == ST_PULSE && cbit(cmd, BIT_USEL_EN)) |=> drv.unit_select_out && drv.unit_receiver_enable;
  endproperty
  a_usel_en: assert property (p_usel_en) else $error("unit select not enabled");

  property p_addr_drop;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      (ph1 && state == ST_DROP) |=> !drv.addr_gate;
  endproperty
  a_addr_drop: assert property (p_addr_drop) else $error("address not removed");

  c_done: cover property (@(posedge clk_sys_i) disable iff (!rstn_i) done);
  c_csel: cover property (@(posedge clk_sys_i) disable iff (!rstn_i) $rose(drv.control_select_line));
  c_rel: cover property (@(posedge clk_sys_i) disable iff (!rstn_i) drv.release_strobe);
  c_rf: cover property (@(posedge clk_sys_i) disable iff (!rstn_i) ph1 && state == ST_STEP1 && from_rf);
  c_dd: cover property (@(posedge clk_sys_i) disable iff (!rstn_i) ph1 && state == ST_STEP1 && from_rf && dd);
endmodule : dfs_sequencer

// [sim/dfs_drive_model.sv]
`timescale 1ns/1ps
module dfs_drive_model (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // drive lines
  input wire dfs_pkg::dfs_drive_t drive_i,
  // what the drive took in
  output logic [9:0] addr_o,
  output logic [9:0] ctrl_o,
  output logic [7:0] rel_cnt_o
);
  import dfs_pkg::*;
  logic rel_q;
  // a drive only takes the address while a tag and the address gate stand together
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      addr_o <= 10'h000;
      ctrl_o <= 10'h000;
      rel_cnt_o <= 8'h00;
      rel_q <= 1'b0;
    end else begin
      rel_q <= drive_i.release_strobe;
      if (drive_i.addr_gate && (drive_i.tags != 4'h0)) begin
        addr_o <= drive_i.info;
      end
      if (drive_i.control_info_gate) begin
        ctrl_o <= drive_i.info;
      end
      if (drive_i.release_strobe && !rel_q) begin
        rel_cnt_o <= rel_cnt_o + 8'h01;
      end
    end
  end
endmodule : dfs_drive_model

// [sim/disk_function_tag_sequencer_test.sv]
`timescale 1ns/1ps
module disk_function_tag_sequencer_test;
  import dfs_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rstn_i = 1'b0;
  logic command_read_strobe_i = 1'b0;
  logic [31:0] cmd_word_i = 32'h0;
  logic execute_enable_strobe_i = 1'b0;
  logic disable_control_select_i = 1'b0;
  logic internal_phase_one_i = 1'b0;
  logic [15:0] rf_data_i = 16'h0;
  logic [15:0] rf_mem [16];
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic function_command_decode_o;
  logic disk_function_decode_o;
  logic regfile_counter_load_decode_o;
  logic [3:0] rf_addr_o;
  logic command_done_o;
  logic busy_o;
  dfs_drive_t drive_o;
  logic [9:0] m_addr;
  logic [9:0] m_ctrl;
  logic [7:0] m_rel;
  logic [31:0] d;
  int err_count = 0;
  int compares = 0;

  dfs_sequencer dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .command_read_strobe_i(command_read_strobe_i),
    .cmd_word_i(cmd_word_i), .execute_enable_strobe_i(execute_enable_strobe_i),
    .disable_control_select_i(disable_control_select_i), .function_command_decode_o(function_command_decode_o),
    .disk_function_decode_o(disk_function_decode_o), .regfile_counter_load_decode_o(regfile_counter_load_decode_o),
    .rf_addr_o(rf_addr_o), .rf_data_i(rf_data_i), .command_done_o(command_done_o), .busy_o(busy_o),
    .internal_phase_one_i(internal_phase_one_i), .drive_o(drive_o), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  dfs_drive_model drv (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .drive_i(drive_o), .addr_o(m_addr),
    .ctrl_o(m_ctrl), .rel_cnt_o(m_rel));

  initial begin
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  // register file answers one cycle after the address, as a synchronous memory would
  always_ff @(posedge clk_sys_i) begin
    rf_data_i <= rf_mem[rf_addr_o];
  end

  task report_and_stop;
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic av_xfer(input logic [3:0] a, input logic wr, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 16);
    rd = avs_readdata;
    if (avs_waitrequest !== 1'b0) begin
      err_count++;
      report_and_stop();
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys_i);
  endtask : av_xfer

  // one phase-one pulse, watching for the done pulse meanwhile
  task automatic phase(output logic dn);
    dn = 1'b0;
    internal_phase_one_i <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys_i);
      if (i == 1) internal_phase_one_i <= 1'b0;
      if (command_done_o === 1'b1) dn = 1'b1;
    end
  endtask : phase

  function automatic logic [31:0] mk(input logic [6:0] t, input logic [8:0] o, input logic b24, input logic b25,
    input logic [3:0] a);
    return {8'hc0, t, o, b24, b25, 2'b00, a};
  endfunction : mk

  // fl = control select, receivers on, release/fault strobes, disable reserve
  task automatic run(input logic [31:0] cmd, input logic [9:0] ei, input logic [3:0] et, input logic [3:0] fl);
    logic dn;
    logic early;
    logic [31:0] st;
    early = 1'b0;
    cmd_word_i <= cmd;
    command_read_strobe_i <= 1'b1;
    @(posedge clk_sys_i);
    command_read_strobe_i <= 1'b0;
    @(posedge clk_sys_i);
    chk(disk_function_decode_o, 1'b1);
    chk(function_command_decode_o, 1'b1);
    chk(regfile_counter_load_decode_o, 1'b1);
    execute_enable_strobe_i <= 1'b1;
    @(posedge clk_sys_i);
    execute_enable_strobe_i <= 1'b0;
    @(posedge clk_sys_i);
    chk(rf_addr_o, cmd[3:0]);
    chk(busy_o, 1'b1);
    av_xfer(4'h4, 1'b0, 32'h0, st);
    chk(st[3:2], {cmd[6], cmd[7]});
    for (int s = 1; s <= 5; s++) begin
      phase(dn);
      if (s < 5) early = early | dn;
      if (s == 2) begin
        chk(drive_o.tags, et);
        chk(drive_o.info, ei);
        chk(drive_o.control_select_line, fl[3]);
        chk(drive_o.control_info_gate, fl[3]);
        chk(drive_o.addr_gate, !fl[3]);
      end
      if (s == 3) begin
        chk(drive_o.tags, 4'h0);
        chk({drive_o.release_strobe, drive_o.fault_clear_strobe}, {fl[1], fl[1]});
        chk(drive_o.disable_reserve_signal, fl[0]);
        chk(drive_o.unit_receiver_enable, fl[2]);
        chk(drive_o.unit_select_out, fl[2]);
      end
      if (s == 4) chk(drive_o.addr_gate, 1'b0);
    end
    chk(early, 1'b0);
    chk(dn, 1'b1);
    chk(busy_o, 1'b0);
    chk({drive_o.release_strobe, drive_o.disable_reserve_signal}, 2'b00);
  endtask : run

  initial begin
    for (int i = 0; i < 16; i++) rf_mem[i] = 16'h0;
    rf_mem[5] = 16'hb3c7;
    rf_mem[10] = 16'h02ff;
    repeat (5) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    @(posedge clk_sys_i);
    chk(drive_o, '0);
    chk(busy_o, 1'b0);
    av_xfer(4'h4, 1'b0, 32'h0, d);
    chk(d, 32'h0);
    av_xfer(4'hf, 1'b1, 32'hffffffff, d);
    av_xfer(4'hf, 1'b0, 32'h0, d);
    chk(d, 32'h0);
    // unit select with both strobes and disable reserve, from the operand
    run(mk(7'h48, 9'h1fe, 1'b1, 1'b0, 4'h3), 10'h1fe, 4'b0100, 4'b0111);
    chk(drive_o.unit_sel, 6'h3b);
    av_xfer(4'h4, 1'b0, 32'h0, d);
    chk(d[9:4], 6'h3b);
    // deselect and head load from the register file, bit 9 padded off
    run(mk(7'h22, 9'h000, 1'b0, 1'b1, 4'h5), 10'h1c7, 4'b0001, 4'b0000);
    av_xfer(4'h0, 1'b1, 32'h1, d);
    av_xfer(4'h0, 1'b0, 32'h0, d);
    chk(d, 32'h1);
    run(mk(7'h04, 9'h000, 1'b0, 1'b1, 4'ha), 10'h2ff, 4'b0010, 4'b0000);
    av_xfer(4'h0, 1'b1, 32'h0, d);
    run(mk(7'h01, 9'h0c3, 1'b0, 1'b0, 4'h0), 10'h0c3, 4'b0000, 4'b1000);
    repeat (4) @(posedge clk_sys_i);
    chk(drive_o.control_select_line, 1'b1);
    disable_control_select_i <= 1'b1;
    @(posedge clk_sys_i);
    disable_control_select_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    chk(drive_o.control_select_line, 1'b0);
    run(mk(7'h10, 9'h155, 1'b1, 1'b0, 4'h0), 10'h155, 4'b1000, 4'b0001);
    // an execute strobe with no decoded command is ignored
    execute_enable_strobe_i <= 1'b1;
    @(posedge clk_sys_i);
    execute_enable_strobe_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    chk(busy_o, 1'b0);
    chk(m_addr, 10'h155);
    chk(m_ctrl, 10'h0c3);
    chk(m_rel, 8'h01);
    report_and_stop();
  end
endmodule : disk_function_tag_sequencer_test
